// File: srw_supervisor.sv
// Supervisor: resets, window watchdog, TX time-out, temperature and modes
`timescale 1ns/1ps
`default_nettype none
`include "srw_map.svh"
module srw_supervisor
   import srw_pkg::*;
#(
   parameter int CLK_KHZ  = `SRW_CLK_KHZ,
   parameter int TCL_CYC  = `SRW_TCL_MS * CLK_KHZ,
   parameter int TSV_CYC  = `SRW_TSV_END_MS * CLK_KHZ,
   parameter int RES_CYC  = `SRW_RES_DEF_MS * CLK_KHZ,
   parameter int RES1_CYC = `SRW_RES_OPT1_MS * CLK_KHZ,
   parameter int RES2_CYC = `SRW_RES_OPT2_MS * CLK_KHZ,
   parameter int RES3_CYC = `SRW_RES_OPT3_MS * CLK_KHZ,
   parameter int TXTO_CYC = `SRW_TXTO_MS * CLK_KHZ,
   parameter int FILT_CYC = `SRW_FILT_CYC
)
(
   // Clock and synchronous reset (the supply brownout reset is a separate input, synchronised here)
   input  wire logic        clk,
   input  wire logic        rst,
   // Analog comparators, asynchronous
   input  wire logic        supply_brownout_reset_n,
   input  wire logic        vcc_above_release,
   input  wire logic        vcc_below_assert,
   input  wire logic        temp_shutdown_hot,
   input  wire logic        temp_returned,
   input  wire logic        temp_warning_hot,
   input  wire logic        lin_wake,
   input  wire logic        tx_pin,
   // Factory options and decoded serial port commands
   input  wire srw_otp_type otp,
   input  wire srw_cmd_type cmd,
   input  wire logic        diag_clear,
   // Outputs
   output logic             regulator_on,
   output logic             transceiver_on,
   output logic             lin_tx_dominant,
   output logic             low_slew_active,
   output logic             reset_pin_low,
   output logic             uv_reset_n,
   output logic [1:0]       uv_threshold,
   output logic             temp_warning_flag,
   output srw_mode_type     mode
);
   typedef struct packed
   {
      logic [1:0]   bor_sync;
      logic [1:0]   above_sync;
      logic [1:0]   below_sync;
      logic [1:0]   hot_sync;
      logic [1:0]   ret_sync;
      logic [1:0]   warn_sync;
      logic [1:0]   wake_sync;
      logic [1:0]   tx_sync;
      srw_mode_type mode;
      logic         bor_seen;
      logic         uv_n;
      logic         low_slew;
      logic         warn_flag;
      logic         wd_reset;
      logic         wd_running;
      logic         tx_block;
      logic         reset_out_prev;
      logic         rst_release_pend;
   } srw_state_type;

   srw_state_type state;
   srw_state_type next_state;

   // Resolved synchronised levels
   logic bor_ok;
   logic vcc_good;
   logic vcc_bad;
   logic hot;
   logic cooled;
   logic tx_low;
   logic wd_active;
   logic wd_clear;
   logic rel_hit;
   logic filt_hit;
   logic tcl_hit;
   logic tsv_hit;
   logic wdres_hit;
   logic txto_hit;
   logic [31:0] hold_limit;
   logic [31:0] win_scale_tcl;
   logic [31:0] win_scale_tsv;

   assign bor_ok   = state.bor_sync[1];
   assign vcc_good = state.above_sync[1];
   assign vcc_bad  = state.below_sync[1];
   // R5: option bit gates the monitor
   assign hot      = state.hot_sync[1] && otp.temp_mon_enable;
   assign cooled   = state.ret_sync[1];
   assign tx_low   = !state.tx_sync[1];

   // Window scale: select code stretches both windows by quarters, code 0 is the base
   function automatic logic [31:0] srw_scale(input int base, input logic [2:0] sel);
      logic [35:0] product;
      product = 36'(base) * 36'({1'b0, sel} + 4'h4);
      return 32'(product >> (`SRW_WIN_SCALE_BITS - 1));
   endfunction : srw_scale

   // R25: reset hold selection
   always_comb
   begin
      case (otp.reset_hold_sel)
         2'h1:    hold_limit = 32'(RES1_CYC);
         2'h2:    hold_limit = 32'(RES2_CYC);
         2'h3:    hold_limit = 32'(RES3_CYC);
         default: hold_limit = 32'(RES_CYC);
      endcase
   end

   // R17 R23 R24: factory window timing select
   assign win_scale_tcl = srw_scale(TCL_CYC, otp.wdog_window_sel);
   assign win_scale_tsv = srw_scale(TSV_CYC, otp.wdog_window_sel);

   // R10: release filter for the undervoltage reset
   srw_counter u_release
   (
      .clk     (clk),
      .rst     (rst),
      .clear   (!vcc_good || state.uv_n),
      .run     (state.mode == srw_mode_normal),
      .limit   (hold_limit),
      .reached (rel_hit)
   );

   // R11: assert filter for the undervoltage reset
   srw_counter u_filter
   (
      .clk     (clk),
      .rst     (rst),
      .clear   (!vcc_bad || !state.uv_n),
      .run     (1'b1),
      .limit   (32'(FILT_CYC)),
      .reached (filt_hit)
   );

   // R16: watchdog only after reset pin high, and not in undervoltage
   // R21: and only in normal mode with the factory enable
   assign wd_active = otp.wdog_enable && state.uv_n && !vcc_bad && !state.wd_reset
                      && state.mode == srw_mode_normal && state.wd_running;
   // R27: timing restarts on accepted trigger and on reset release
   assign wd_clear  = !wd_active || (cmd.wdog_trigger && tcl_hit);

   srw_counter u_closed
   (
      .clk     (clk),
      .rst     (rst),
      .clear   (wd_clear),
      .run     (1'b1),
      .limit   (win_scale_tcl),
      .reached (tcl_hit)
   );

   srw_counter u_service
   (
      .clk     (clk),
      .rst     (rst),
      .clear   (wd_clear),
      .run     (1'b1),
      .limit   (win_scale_tsv),
      .reached (tsv_hit)
   );

   // R15: watchdog reset held low for the hold time
   srw_counter u_wdres
   (
      .clk     (clk),
      .rst     (rst),
      .clear   (!state.wd_reset),
      .run     (1'b1),
      .limit   (hold_limit),
      .reached (wdres_hit)
   );

   // R18 R26: TX dominant time-out; R12 clears it with the undervoltage reset
   srw_counter u_txto
   (
      .clk     (clk),
      .rst     (rst),
      .clear   (!tx_low || !state.uv_n || state.mode != srw_mode_normal),
      .run     (1'b1),
      .limit   (32'(TXTO_CYC)),
      .reached (txto_hit)
   );

   always_comb
   begin
      next_state = state;
      next_state.bor_sync   = {state.bor_sync[0], supply_brownout_reset_n};
      next_state.above_sync = {state.above_sync[0], vcc_above_release};
      next_state.below_sync = {state.below_sync[0], vcc_below_assert};
      next_state.hot_sync   = {state.hot_sync[0], temp_shutdown_hot};
      next_state.ret_sync   = {state.ret_sync[0], temp_returned};
      next_state.warn_sync  = {state.warn_sync[0], temp_warning_hot};
      next_state.wake_sync  = {state.wake_sync[0], lin_wake};
      next_state.tx_sync    = {state.tx_sync[0], tx_pin};
      next_state.reset_out_prev = reset_pin_low;

      if (!bor_ok)
      begin
         // R6: brownout overrides all; R7 clears mode and diagnostics
         // R8: low slew cancelled
         next_state.mode      = srw_mode_normal;
         next_state.bor_seen  = 1'b0;
         next_state.uv_n      = 1'b0;
         next_state.low_slew  = 1'b0;
         next_state.warn_flag = 1'b0;
         next_state.wd_reset  = 1'b0;
         next_state.wd_running = 1'b0;
         next_state.tx_block  = 1'b0;
      end
      else
      begin
         // R2: regulator may start only after brownout release
         next_state.bor_seen = 1'b1;

         // R4: warning flag is sticky; set wins over clear
         if (state.warn_sync[1] && otp.temp_mon_enable)
            next_state.warn_flag = 1'b1;
         else if (diag_clear)
            next_state.warn_flag = 1'b0;

         // R10: release after good output for hold time, counted in normal mode only
         if (rel_hit)
            next_state.uv_n = 1'b1;
         // R11: assert after filtered undervoltage
         else if (filt_hit)
            next_state.uv_n = 1'b0;

         case (state.mode)
            srw_mode_normal:
            begin
               // R3: over-temperature powers down
               if (hot)
                  next_state.mode = srw_mode_thermal;
               // R1: temporary shutdown bit
               else if (cmd.tempsd_set)
                  next_state.mode = srw_mode_tempsd;
               else if (cmd.standby_req)
                  next_state.mode = srw_mode_standby;
               // R20: low slew only as a normal-mode setting
               if (cmd.low_slew_set)
                  next_state.low_slew = 1'b1;
            end
            srw_mode_standby:
            begin
               if (hot)
                  next_state.mode = srw_mode_thermal;
               else if (cmd.tempsd_set)
                  next_state.mode = srw_mode_tempsd;
               else if (cmd.wake_req || state.wake_sync[1])
                  next_state.mode = srw_mode_normal;
            end
            srw_mode_tempsd:
            begin
               // Leave once the temporary shutdown bit clears; the outage makes the reset
               if (!cmd.tempsd_set)
                  next_state.mode = srw_mode_normal;
            end
            default:
            begin
               // R3: cooled back, power up; the outage makes the reset
               if (cooled && !hot)
                  next_state.mode = srw_mode_normal;
            end
         endcase

         // Regulator off forces the undervoltage reset directly
         if (state.mode == srw_mode_tempsd || state.mode == srw_mode_thermal)
            next_state.uv_n = 1'b0;

         // R12: undervoltage reset initialises watchdog and TX time-out
         if (!state.uv_n)
         begin
            next_state.wd_reset   = 1'b0;
            next_state.wd_running = 1'b0;
            next_state.tx_block   = 1'b0;
         end
         else
         begin
            // R16: start after reset pin returned high
            if (!reset_pin_low && state.reset_out_prev)
               next_state.wd_running = 1'b1;
            // R15: early or missing trigger
            if (wd_active && ((cmd.wdog_trigger && !tcl_hit) || tsv_hit))
               next_state.wd_reset = 1'b1;
            else if (state.wd_reset && wdres_hit)
            begin
               next_state.wd_reset   = 1'b0;
               next_state.wd_running = 1'b0;
            end
            // R18: release the bus until TX returns high
            if (txto_hit)
               next_state.tx_block = 1'b1;
            else if (!tx_low)
               next_state.tx_block = 1'b0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         state <= '0;
      else
         state <= next_state;
   end

   // R9: reset pin only from undervoltage reset and watchdog
   assign reset_pin_low = !state.uv_n || state.wd_reset;
   assign uv_reset_n    = state.uv_n;
   // R13: threshold selection passed to the comparator
   assign uv_threshold  = otp.uv_threshold_sel;
   assign regulator_on  = state.bor_seen && (state.mode == srw_mode_normal
                          || state.mode == srw_mode_standby);
   // R19: normal mode relays TX
   assign transceiver_on  = state.bor_seen && state.mode == srw_mode_normal;
   assign lin_tx_dominant = transceiver_on && tx_low && !state.tx_block;
   assign low_slew_active = state.low_slew && state.mode == srw_mode_normal;
   assign temp_warning_flag = state.warn_flag;
   assign mode = state.mode;

   // R9: reset pin never low while both sources are inactive
   reset_sources_a: assert property (@(posedge clk) disable iff (rst) // R9
      (state.uv_n && !state.wd_reset) |-> !reset_pin_low)
      else $error("reset pin driven by other source");
   // R6: no regulator while brownout held
   brownout_master_a: assert property (@(posedge clk) disable iff (rst) // R6
      !state.bor_sync[1] |=> !regulator_on && !transceiver_on)
      else $error("regulator on under brownout");
   // R8: low slew cleared by brownout
   slew_cancel_a: assert property (@(posedge clk) disable iff (rst) // R8
      !state.bor_sync[1] |=> !state.low_slew)
      else $error("low slew survived brownout");
   // R3: hot in normal leads to thermal mode
   thermal_entry_a: assert property (@(posedge clk) disable iff (rst) // R3
      (bor_ok && hot && state.mode == srw_mode_normal) |=> mode == srw_mode_thermal)
      else $error("over-temperature ignored");
   // R15: watchdog reset pulls the pin
   wd_reset_pin_a: assert property (@(posedge clk) disable iff (rst) // R15
      state.wd_reset |-> reset_pin_low)
      else $error("watchdog reset not on pin");
   // R21: watchdog idle outside normal
   standby_wd_off_a: assert property (@(posedge clk) disable iff (rst) // R21
      (state.mode != srw_mode_normal) |-> !wd_active)
      else $error("watchdog active outside normal");
   // R18: bus released after time-out
   tx_release_a: assert property (@(posedge clk) disable iff (rst) // R18
      state.tx_block |-> !lin_tx_dominant)
      else $error("bus dominant after time-out");
   // R12: undervoltage clears watchdog state
   uv_init_wd_a: assert property (@(posedge clk) disable iff (rst) // R12
      (bor_ok && !state.uv_n) |=> !state.wd_running && !state.tx_block)
      else $error("watchdog not initialised");
   // R24: trigger inside the closed window starts a watchdog reset
   early_trigger_a: assert property (@(posedge clk) disable iff (rst) // R24
      (bor_ok && wd_active && cmd.wdog_trigger && !tcl_hit) |=> state.wd_reset)
      else $error("early trigger ignored");
endmodule : srw_supervisor
`default_nettype wire

// File: srw_map.svh
// Constant map and functional notes for the supervisor block
// Functional notes
// R1: Temporary-shutdown bit written over the serial port powers the regulator down.
// R2: Regulator stays off until the supply brownout reset releases.
// R3: Over-temperature powers down; cooling powers up again and issues a reset.
// R4: Rising past the warning threshold sets the diagnostic warning flag.
// R5: An option bit enables or disables temperature monitoring.
// R6: Supply brownout reset is master; regulator and transceiver off while asserted.
// R7: Brownout in standby or sleep clears mode and diagnostics; recovery enters normal.
// R8: Brownout cancels low slew; recovery returns normal mode with normal slew.
// R9: Reset pin is driven only by output-undervoltage reset and the watchdog.
// R10: Undervoltage reset releases after output stays good longer than hold time; the code counts the hold time only in normal mode.
// R11: Undervoltage reset asserts after output stays low longer than filter time.
// R12: Undervoltage reset clears watchdog, TX time-out, test and port logic, not controls.
// R13: A two-bit factory field selects the undervoltage threshold level.
// R14: Microcontroller sends one trigger in each service window when enabled.
// R15: Missing or early trigger drives reset low for the reset hold time.
// R16: Watchdog starts after reset pin goes high; off while output is undervoltage.
// R17: Factory bit enables the watchdog; three-bit field selects window timing.
// R18: TX low runs a dominant time-out; expiry releases the bus recessive.
// R19: Normal mode after power-up relays TX to the bus.
// R20: Reduced slew option applies only in normal mode.
// R21: Standby disables both watchdogs, keeps wake-up and temperature monitor.
// R22: During standby the microcontroller holds enable low and TX high.
// R23: Service window is 100 to 200 ms after the previous trigger.
// R24: Closed window is the first 100 ms after the previous trigger.
// R25: Reset hold time selectable as 4, 16 or 32 ms besides the default.
// R26: TX dominant time-out is typically one second.
// R27: Closed window restarts at each accepted trigger and after each reset release.
`ifndef SRW_MAP_SVH
`define SRW_MAP_SVH
`define SRW_CLK_KHZ        25000
`define SRW_TCL_MS         100
`define SRW_TSV_END_MS     200
`define SRW_RES_DEF_MS     8
`define SRW_RES_OPT1_MS    4
`define SRW_RES_OPT2_MS    16
`define SRW_RES_OPT3_MS    32
`define SRW_TXTO_MS        1000
`define SRW_FILT_US        4
`define SRW_FILT_CYC       ((`SRW_FILT_US * `SRW_CLK_KHZ + 999) / 1000)
`define SRW_WIN_SCALE_BITS 3
`endif

// File: srw_pkg.sv
// Types for the supervisor block
package srw_pkg;
   typedef enum logic [1:0]
   {
      srw_mode_normal  = 2'b00,
      srw_mode_standby = 2'b01,
      srw_mode_tempsd  = 2'b11,
      srw_mode_thermal = 2'b10
   } srw_mode_type;

   typedef struct packed
   {
      logic       wdog_enable;
      logic [2:0] wdog_window_sel;
      logic [1:0] reset_hold_sel;
      logic [1:0] uv_threshold_sel;
      logic       temp_mon_enable;
   } srw_otp_type;

   typedef struct packed
   {
      logic tempsd_set;
      logic low_slew_set;
      logic standby_req;
      logic wake_req;
      logic wdog_trigger;
   } srw_cmd_type;
endpackage : srw_pkg

// File: srw_counter.sv
// Cycle counter with clear and terminal flag
`timescale 1ns/1ps
`default_nettype none
module srw_counter
#(
   parameter int WIDTH = 32
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Control
   input  wire logic             clear,
   input  wire logic             run,
   input  wire logic [WIDTH-1:0] limit,
   // Status
   output logic                  reached
);
   typedef struct packed
   {
      logic [WIDTH-1:0] count;
      logic             hit;
   } srwc_state_type;

   srwc_state_type state;
   srwc_state_type next_state;

   always_comb
   begin
      next_state = state;
      if (clear || !run)
      begin
         next_state.count = '0;
         next_state.hit   = 1'b0;
      end
      else if (state.count >= limit)
         next_state.hit = 1'b1;
      else
         next_state.count = state.count + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         state <= '0;
      else
         state <= next_state;
   end

   assign reached = state.hit;
endmodule : srw_counter
`default_nettype wire

// File: srw_mcu_model.sv
// Microcontroller model: window service triggers and TX pin
`timescale 1ns/1ps
`default_nettype none
module srw_mcu_model
   import srw_pkg::*;
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // Device side
   input  wire logic          reset_pin_low,
   input  wire srw_mode_type  mode,
   // Bench control
   input  wire logic          svc_enable,
   input  wire logic [15:0]   svc_delay,
   input  wire logic          tx_low_req,
   // Pins towards the device
   output var  logic          wdog_trigger,
   output var  logic          tx_pin
);
   logic [15:0] cnt;

   // one trigger per window
   // Counts from each reset release, so a held reset restarts the service timing
   always_ff @(negedge clk)
   begin
      if (rst || reset_pin_low || !svc_enable)
      begin
         cnt <= 16'h0000;
         wdog_trigger <= 1'b0;
      end
      else if (cnt >= svc_delay)
      begin
         cnt <= 16'h0000;
         wdog_trigger <= 1'b1;
      end
      else
      begin
         cnt <= cnt + 16'h0001;
         wdog_trigger <= 1'b0;
      end
   end

   assign tx_pin = (mode == srw_mode_standby) ? 1'b1 : !tx_low_req;
endmodule : srw_mcu_model
`default_nettype wire

// File: srw_supervisor_tb.sv
// Self-checking bench for the supervisor block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
   begin n_compared++; if ((gt) !== (ex)) begin fail_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); end end
module srw_supervisor_tb;
   import srw_pkg::*;
   localparam int TCL = 50;
   localparam int TSV = 100;
   localparam int RES = 20;
   localparam int TXTO = 200;
   localparam int FILT = 8;
   int fail_count = 0;
   int n_compared = 0;
   int n;
   int hits;
   int holds [4] = '{20, 10, 30, 40};
   logic clk = 1'b0, rst = 1'b1, bor_n = 1'b0, vabove = 1'b0, vbelow = 1'b1;
   logic t_hot = 1'b0, t_ret = 1'b0, t_warn = 1'b0, wake = 1'b0, dclr = 1'b0;
   logic trig, tx_pin, tx_low = 1'b0, svc_en = 1'b1;
   logic [15:0] svc_dly = 16'h004b;
   srw_otp_type otp = '{1'b1, 3'h0, 2'h0, 2'h0, 1'b1};
   srw_cmd_type tb_cmd = 5'h00;
   srw_cmd_type cmd;
   logic reg_on, xcvr_on, lin_dom, slew, rpl, uv_n, warn;
   logic [1:0] uv_thr;
   srw_mode_type mode;

   always_comb
   begin
      cmd = tb_cmd;
      cmd.wdog_trigger = trig;
   end

   srw_supervisor #(.TCL_CYC(TCL), .TSV_CYC(TSV), .RES_CYC(RES), .RES1_CYC(10),
      .RES2_CYC(30), .RES3_CYC(40), .TXTO_CYC(TXTO), .FILT_CYC(FILT)) dut (
      .clk(clk), .rst(rst), .supply_brownout_reset_n(bor_n), .vcc_above_release(vabove),
      .vcc_below_assert(vbelow), .temp_shutdown_hot(t_hot), .temp_returned(t_ret),
      .temp_warning_hot(t_warn), .lin_wake(wake), .tx_pin(tx_pin), .otp(otp), .cmd(cmd),
      .diag_clear(dclr), .regulator_on(reg_on), .transceiver_on(xcvr_on),
      .lin_tx_dominant(lin_dom), .low_slew_active(slew), .reset_pin_low(rpl),
      .uv_reset_n(uv_n), .uv_threshold(uv_thr), .temp_warning_flag(warn), .mode(mode));

   srw_mcu_model mcu (.clk(clk), .rst(rst), .reset_pin_low(rpl), .mode(mode),
      .svc_enable(svc_en), .svc_delay(svc_dly), .tx_low_req(tx_low),
      .wdog_trigger(trig), .tx_pin(tx_pin));

   initial
   begin
      forever #20 clk = !clk;
   end

   task cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc

   task pulse(input int b);
      @(negedge clk) tb_cmd[b] = 1'b1;
      @(negedge clk) tb_cmd[b] = 1'b0;
   endtask : pulse

   // Bounded wait for the reset pin to reach a level
   task automatic wait_rpl(input logic v, input int lim, output int k);
      k = 0;
      while (rpl !== v && k < lim)
      begin
         @(negedge clk);
         k++;
      end
   endtask : wait_rpl

   task automatic quiet(input int k, output int h);
      h = 0;
      repeat (k)
      begin
         @(negedge clk);
         if (rpl !== 1'b0) h++;
      end
   endtask : quiet

   task automatic hold_check(input int h);
      int a;
      int k;
      wait_rpl(1'b1, 400, a);
      wait_rpl(1'b0, 1000, k);
      `CHK("hold length", 1'b1, k >= h - 1 && k <= h + 6);
   endtask : hold_check

   task results;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   initial
   begin
      #(40 * 60000);
      fail_count++;
      results;
   end

   initial
   begin
      cyc(5);
      rst = 1'b0;
      cyc(10);
      `CHK("regulator pre brownout", 1'b0, reg_on);
      `CHK("transceiver pre brownout", 1'b0, xcvr_on);
      bor_n = 1'b1;
      vabove = 1'b1;
      vbelow = 1'b0;
      wait_rpl(1'b0, 200, n);
      `CHK("release delay", 1'b1, n >= RES && n <= RES + 12);
      `CHK("regulator on", 1'b1, reg_on);
      `CHK("mode after power up", srw_mode_normal, mode);
      tx_low = 1'b1;
      cyc(5);
      `CHK("tx relayed", 1'b1, lin_dom);
      cyc(TXTO - 20);
      `CHK("dominant before time-out", 1'b1, lin_dom);
      cyc(30);
      `CHK("released after time-out", 1'b0, lin_dom);
      tx_low = 1'b0;
      t_warn = 1'b1;
      cyc(5);
      `CHK("warning set", 1'b1, warn);
      t_warn = 1'b0;
      // This clear meets the last synchronised warning sample
      @(negedge clk) dclr = 1'b1;
      @(negedge clk) dclr = 1'b0;
      `CHK("warning set wins", 1'b1, warn);
      @(negedge clk) dclr = 1'b1;
      @(negedge clk) dclr = 1'b0;
      cyc(2);
      `CHK("warning cleared", 1'b0, warn);
      quiet(5 * TSV, hits);
      `CHK("serviced resets", 0, hits);
      // Early trigger for every hold-time option
      svc_dly = 16'h000a;
      for (int s = 0; s < 4; s++)
      begin
         otp.reset_hold_sel = s[1:0];
         hold_check(holds[s]);
      end
      otp.reset_hold_sel = 2'h0;
      svc_en = 1'b0;
      wait_rpl(1'b1, 400, n);
      `CHK("missing trigger time", 1'b1, n >= TSV - 2 && n <= TSV + 6);
      wait_rpl(1'b0, 400, n);
      otp.wdog_window_sel = 3'h4;
      wait_rpl(1'b1, 600, n);
      `CHK("scaled window time", 1'b1, n >= 2 * TSV - 2 && n <= 2 * TSV + 6);
      wait_rpl(1'b0, 400, n);
      otp.wdog_enable = 1'b0;
      quiet(3 * TSV, hits);
      `CHK("watchdog disabled", 0, hits);
      otp = '{1'b1, 3'h0, 2'h0, 2'h0, 1'b1};
      svc_en = 1'b1;
      svc_dly = 16'h004b;
      t_hot = 1'b1;
      cyc(5);
      `CHK("thermal regulator", 1'b0, reg_on);
      `CHK("thermal reset pin", 1'b1, rpl);
      `CHK("thermal mode", srw_mode_thermal, mode);
      t_hot = 1'b0;
      t_ret = 1'b1;
      cyc(5);
      `CHK("cooled regulator", 1'b1, reg_on);
      wait_rpl(1'b0, 200, n);
      `CHK("cooled release", 1'b0, rpl);
      t_ret = 1'b0;
      otp.temp_mon_enable = 1'b0;
      t_hot = 1'b1;
      cyc(6);
      `CHK("monitor off", 1'b1, reg_on);
      t_hot = 1'b0;
      // Let the synchronised hot level drain before the monitor returns
      cyc(3);
      otp.temp_mon_enable = 1'b1;
      tb_cmd.tempsd_set = 1'b1;
      cyc(4);
      `CHK("shutdown regulator", 1'b0, reg_on);
      `CHK("shutdown reset pin", 1'b1, rpl);
      tb_cmd.tempsd_set = 1'b0;
      cyc(4);
      `CHK("shutdown exit", 1'b1, reg_on);
      wait_rpl(1'b0, 200, n);
      // Spike shorter than the filter must not reset
      vbelow = 1'b1;
      cyc(FILT - 4);
      vbelow = 1'b0;
      cyc(6);
      `CHK("spike filtered", 1'b1, uv_n);
      vabove = 1'b0;
      vbelow = 1'b1;
      cyc(FILT + 6);
      `CHK("undervoltage reset", 1'b0, uv_n);
      `CHK("undervoltage pin", 1'b1, rpl);
      vabove = 1'b1;
      vbelow = 1'b0;
      wait_rpl(1'b0, 200, n);
      `CHK("undervoltage release", 1'b1, n >= RES && n <= RES + 12);
      svc_en = 1'b0;
      pulse(2);
      cyc(3);
      `CHK("standby mode", srw_mode_standby, mode);
      quiet(3 * TSV, hits);
      `CHK("standby watchdog off", 0, hits);
      pulse(3);
      cyc(3);
      `CHK("slew refused", 1'b0, slew);
      t_warn = 1'b1;
      cyc(5);
      t_warn = 1'b0;
      bor_n = 1'b0;
      cyc(6);
      `CHK("brownout regulator", 1'b0, reg_on);
      bor_n = 1'b1;
      cyc(8);
      `CHK("brownout recovery", srw_mode_normal, mode);
      `CHK("diagnostics cleared", 1'b0, warn);
      svc_en = 1'b1;
      wait_rpl(1'b0, 200, n);
      pulse(3);
      cyc(3);
      `CHK("low slew set", 1'b1, slew);
      bor_n = 1'b0;
      cyc(6);
      bor_n = 1'b1;
      wait_rpl(1'b0, 200, n);
      `CHK("low slew cancelled", 1'b0, slew);
      `CHK("normal after recovery", srw_mode_normal, mode);
      pulse(2);
      cyc(1);
      `CHK("standby again", srw_mode_standby, mode);
      pulse(1);
      cyc(1);
      `CHK("local wake", srw_mode_normal, mode);
      pulse(2);
      cyc(1);
      `CHK("standby before wake", srw_mode_standby, mode);
      wake = 1'b1;
      cyc(5);
      `CHK("remote wake", srw_mode_normal, mode);
      wake = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         otp.uv_threshold_sel = i[1:0];
         cyc(1);
         `CHK("threshold select", i[1:0], uv_thr);
      end
      results;
   end
endmodule : srw_supervisor_tb
`default_nettype wire
